// file: htr_defs.svh
// Purpose: shared constants of the humidity/temperature readout link
// Assumes: 40 MHz sys_clk, 100 kHz bus clock
// Notes:   times in ms, cycle counts derived from them
`ifndef HTR_DEFS_SVH
`define HTR_DEFS_SVH
`define HTR_CLK_KHZ   40000
`define HTR_SCL_KHZ   100
`define HTR_QDIV      ((`HTR_CLK_KHZ + 4 * `HTR_SCL_KHZ - 1) / (4 * `HTR_SCL_KHZ))
`define HTR_PWR_MS    100
`define HTR_GAP_MS    10
`define HTR_CONV_MS   80
`define HTR_POLL_MS   10
`define HTR_MEAS_MS   40
`define HTR_ADDR      7'h38
`define HTR_RD_ADDR   8'h71
`define HTR_WR_ADDR   8'h70
`define HTR_CMD_TRIG  8'hac
`define HTR_TRIG_P0   8'h33
`define HTR_TRIG_P1   8'h00
`define HTR_INIT_R0   8'h1b
`define HTR_INIT_R1   8'h1c
`define HTR_INIT_R2   8'h1e
`define HTR_INIT_VAL  8'h00
`define HTR_CAL_MASK  8'h18
`define HTR_CAL_LO    3
`define HTR_CAL_HI    4
`define HTR_BUSY_BIT  7
`define HTR_CRC_INIT  8'hff
`define HTR_CRC_POLY  8'h31
`define HTR_HDR       4'h2
`define HTR_WR_LEN    4'h3
`define HTR_NDATA     4'h6
`define HTR_ACK_BIT   4'h8
`define HTR_LAST_REG  2'h2
`define HTR_RH_SCALE  34'h2710
`define HTR_T_SCALE   35'h4e20
`define HTR_T_OFS     16'h1388
`endif

// file: htr_pkg.sv
// Purpose: types and check function shared by both ends
// Assumes: htr_defs.svh constants
// Notes:   crc is msb first over 48 bits
`include "htr_defs.svh"
package htr_pkg;
	typedef enum logic [1:0] {OP_START, OP_WR, OP_RD, OP_STOP} htr_op_e;
	typedef enum logic [1:0] {E_IDLE, E_START, E_BITS, E_STOP} htr_eng_e;
	typedef enum logic [3:0] {S_PWR, S_IDLE, S_STAT, S_INIT, S_GAP, S_TRIG, S_CONV,
		S_POLLW, S_READ} htr_hst_e;
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_WACK, D_WDATA, D_RDATA, D_RACK} htr_dst_e;

	function automatic logic [7:0] htr_crc8(input logic [47:0] d);
		logic [7:0] c;
		c = `HTR_CRC_INIT;
		for (int i = 47; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ `HTR_CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : htr_crc8
endpackage : htr_pkg

// file: htr_if.sv
// Purpose: two-wire link between host and sensor
// Assumes: open-drain wires with pull-up
// Notes:   wire level resolved from enables
`timescale 1ns/1ps
interface htr_if;
	logic h_scl_o;
	logic h_scl_oe_n;
	logic h_sda_o;
	logic h_sda_oe_n;
	logic d_sda_o;
	logic d_sda_oe_n;
	logic scl;
	logic sda;

	assign scl = h_scl_oe_n | h_scl_o;
	assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);

	modport host (output h_scl_o, h_scl_oe_n, h_sda_o, h_sda_oe_n, input scl, sda);
	modport dev (output d_sda_o, d_sda_oe_n, input scl, sda);
endinterface : htr_if

// file: htr_sensor.sv
// Purpose: sensor end: bus slave, measurement timer, data and check byte
// Assumes: scl only driven by host, no clock stretching
// Notes:   raw values taken from user ports when conversion ends
`timescale 1ns/1ps
`include "htr_defs.svh"
module htr_sensor
	import htr_pkg::*;
#(
	parameter int unsigned MEAS_CYC = `HTR_MEAS_MS * `HTR_CLK_KHZ
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	htr_if.dev               bus,
	input  wire logic [19:0] humidity_raw_value,
	input  wire logic [19:0] temp_raw_value,
	input  wire logic        cal_in,
	output logic             meas_busy
);
	// ----------------------------------------
	// pin synchronisers and edges
	// ----------------------------------------
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic       scl_q_reg;
	logic       sda_q_reg;
	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_q_reg    <= 1'b1;
			sda_q_reg    <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], bus.scl};
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
			scl_q_reg    <= scl_sync_reg[1];
			sda_q_reg    <= sda_sync_reg[1];
		end
	end

	assign rise  = scl_sync_reg[1] & ~scl_q_reg;
	assign fall  = ~scl_sync_reg[1] & scl_q_reg;
	assign start = scl_sync_reg[1] & scl_q_reg & sda_q_reg & ~sda_sync_reg[1];
	assign stop  = scl_sync_reg[1] & scl_q_reg & ~sda_q_reg & sda_sync_reg[1];

	// ----------------------------------------
	// slave state
	// ----------------------------------------
	htr_dst_e    st_reg, st_next;
	logic [3:0]  bit_reg, bit_next;
	logic [7:0]  sh_reg, sh_next;
	logic        drv_reg, drv_next;
	logic        rw_reg, rw_next;
	logic [2:0]  idx_reg, idx_next;
	logic [1:0]  widx_reg, widx_next;
	logic        trig_reg, trig_next;
	logic [7:0]  cmd_reg, cmd_next;
	logic        busy_reg, busy_next;
	logic [31:0] tmr_reg, tmr_next;
	logic [39:0] data_reg, data_next;
	logic        cal_reg, cal_next;
	logic [7:0]  ssent_reg, ssent_next;
	logic [7:0]  stat;
	logic [7:0]  tx;
	logic        load;

	function automatic logic [7:0] tx_byte(input logic [2:0] i, input logic [7:0] s,
		input logic [7:0] ss, input logic [39:0] d);
		case (i)
			3'h0: tx_byte = s;
			3'h1: tx_byte = d[39:32];
			3'h2: tx_byte = d[31:24];
			3'h3: tx_byte = d[23:16];
			3'h4: tx_byte = d[15:8];
			3'h5: tx_byte = d[7:0];
			3'h6: tx_byte = htr_crc8({ss, d});
			default: tx_byte = 8'hff;
		endcase
	endfunction : tx_byte

	always_comb begin
		stat = 8'h00;
		stat[`HTR_BUSY_BIT] = busy_reg;
		stat[`HTR_CAL_LO] = cal_reg;
		stat[`HTR_CAL_HI] = cal_reg;
		tx = tx_byte(idx_reg, stat, ssent_reg, data_reg);
	end

	always_comb begin
		st_next    = st_reg;
		bit_next   = bit_reg;
		sh_next    = sh_reg;
		drv_next   = drv_reg;
		rw_next    = rw_reg;
		idx_next   = idx_reg;
		widx_next  = widx_reg;
		trig_next  = trig_reg;
		cmd_next   = cmd_reg;
		busy_next  = busy_reg;
		tmr_next   = tmr_reg;
		data_next  = data_reg;
		cal_next   = cal_reg | cal_in;
		ssent_next = ssent_reg;
		load       = 1'b0;
		if (busy_reg) begin
			tmr_next = tmr_reg + 32'h1;
			if (tmr_reg == MEAS_CYC - 1) begin
				busy_next = 1'b0;
				data_next = {humidity_raw_value, temp_raw_value};
			end
		end
		if (start) begin
			st_next   = D_ADDR;
			bit_next  = 4'h0;
			drv_next  = 1'b0;
			idx_next  = 3'h0;
			widx_next = 2'h0;
		end else if (stop) begin
			st_next  = D_IDLE;
			drv_next = 1'b0;
		end else begin
			case (st_reg)
				D_ADDR, D_WDATA: begin
					if (rise) begin
						sh_next  = {sh_reg[6:0], sda_sync_reg[1]};
						bit_next = bit_reg + 4'h1;
					end
					if (fall && bit_reg == `HTR_ACK_BIT) begin
						bit_next = 4'h0;
						if (st_reg == D_ADDR && sh_reg[7:1] != `HTR_ADDR) begin
							st_next = D_IDLE;
						end else begin
							drv_next = 1'b1;
							st_next  = D_WACK;
							if (st_reg == D_ADDR) begin
								rw_next = sh_reg[0];
							end else begin
								if (widx_reg != 2'h3) widx_next = widx_reg + 2'h1;
								case (widx_reg)
									2'h0: begin
										cmd_next = sh_reg;
										if (sh_reg == `HTR_INIT_R2) cal_next = 1'b1;
									end
									2'h1: trig_next = (cmd_reg == `HTR_CMD_TRIG) &&
										(sh_reg == `HTR_TRIG_P0);
									2'h2: begin
										if (trig_reg && sh_reg == `HTR_TRIG_P1) begin
											busy_next = 1'b1;
											tmr_next  = 32'h0;
										end
									end
									default: ;
								endcase
							end
						end
					end
				end
				D_WACK: begin
					if (fall) begin
						drv_next = 1'b0;
						st_next  = D_WDATA;
						load     = rw_reg;
					end
				end
				D_RDATA: begin
					if (fall) begin
						if (bit_reg == `HTR_ACK_BIT) begin
							drv_next = 1'b0;
							st_next  = D_RACK;
						end else begin
							drv_next = ~sh_reg[6];
							sh_next  = {sh_reg[6:0], 1'b0};
							bit_next = bit_reg + 4'h1;
						end
					end
				end
				D_RACK: begin
					if (rise && sda_sync_reg[1]) st_next = D_IDLE;
					load = fall;
				end
				default: st_next = D_IDLE;
			endcase
		end
		if (load) begin
			sh_next  = tx;
			drv_next = ~tx[7];
			bit_next = 4'h1;
			st_next  = D_RDATA;
			if (idx_reg == 3'h0) ssent_next = stat;
			if (idx_reg != 3'h7) idx_next = idx_reg + 3'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg    <= D_IDLE;
			bit_reg   <= 4'h0;
			sh_reg    <= 8'h00;
			drv_reg   <= 1'b0;
			rw_reg    <= 1'b0;
			idx_reg   <= 3'h0;
			widx_reg  <= 2'h0;
			trig_reg  <= 1'b0;
			cmd_reg   <= 8'h00;
			busy_reg  <= 1'b0;
			tmr_reg   <= 32'h0;
			data_reg  <= 40'h0;
			cal_reg   <= 1'b0;
			ssent_reg <= 8'h00;
		end else begin
			st_reg    <= st_next;
			bit_reg   <= bit_next;
			sh_reg    <= sh_next;
			drv_reg   <= drv_next;
			rw_reg    <= rw_next;
			idx_reg   <= idx_next;
			widx_reg  <= widx_next;
			trig_reg  <= trig_next;
			cmd_reg   <= cmd_next;
			busy_reg  <= busy_next;
			tmr_reg   <= tmr_next;
			data_reg  <= data_next;
			cal_reg   <= cal_next;
			ssent_reg <= ssent_next;
		end
	end

	assign bus.d_sda_o    = 1'b0;
	assign bus.d_sda_oe_n = ~drv_reg;
	assign meas_busy      = busy_reg;
endmodule : htr_sensor

// file: htr_host.sv
// Purpose: host end: power-up wait, status check, trigger, poll, read, convert
// Assumes: single master, sensor never stretches the clock
// Notes:   results in hundredths of percent and of a degree
// Operation
// - wait 100 ms after power-up
// - fetch status byte via 0x71 read
// - uncalibrated status means initialise three registers
// - after 10 ms send 0xac 0x33 0x00
// - wait 80 ms before reading
// - read six bytes only when not busy
// - sensor reports busy in status bit 7
// - seventh byte is the check value
// - ack sixth byte only when check wanted
// - crc-8 x8+x5+x4+1, preset 0xff
// - calibration check once after power-on
// - humidity equals raw over 2^20 times 100
// - temperature equals raw over 2^20 times 200 minus 50
// - first byte is address 0x38 plus direction
// - receiver pulls data low in ninth clock
`timescale 1ns/1ps
`include "htr_defs.svh"
module htr_host
	import htr_pkg::*;
#(
	parameter int unsigned PWR_CYC  = `HTR_PWR_MS * `HTR_CLK_KHZ,
	parameter int unsigned GAP_CYC  = `HTR_GAP_MS * `HTR_CLK_KHZ,
	parameter int unsigned CONV_CYC = `HTR_CONV_MS * `HTR_CLK_KHZ,
	parameter int unsigned POLL_CYC = `HTR_POLL_MS * `HTR_CLK_KHZ
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	htr_if.host               bus,
	input  wire logic         meas_req,
	input  wire logic         crc_en,
	output logic              busy,
	output logic              done,
	output logic              crc_err,
	output logic [19:0]       humidity_raw_value,
	output logic [19:0]       temp_raw_value,
	output logic [13:0]       rh_centi,
	output logic signed [15:0] temp_centi
);
	// ----------------------------------------
	// data pin synchroniser
	// ----------------------------------------
	logic [1:0] sda_sync_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_sync_reg <= 2'h3;
		end else begin
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
		end
	end

	// ----------------------------------------
	// bit engine
	// ----------------------------------------
	htr_eng_e   eng_reg, eng_next;
	logic [7:0] div_reg, div_next;
	logic [1:0] ph_reg, ph_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] esh_reg, esh_next;
	logic       erd_reg, erd_next;
	logic       eack_reg, eack_next;
	logic       scl_lo_reg, scl_lo_next;
	logic       sda_lo_reg, sda_lo_next;
	logic       nak_reg, nak_next;
	logic       edone_reg, edone_next;
	logic       tick;
	logic       go;
	htr_op_e    op;
	logic [7:0] wbyte;
	logic       ack_send;

	assign tick = (div_reg == 8'(`HTR_QDIV - 1));

	always_comb begin
		eng_next    = eng_reg;
		div_next    = tick ? 8'h00 : div_reg + 8'h01;
		ph_next     = ph_reg;
		bit_next    = bit_reg;
		esh_next    = esh_reg;
		erd_next    = erd_reg;
		eack_next   = eack_reg;
		scl_lo_next = scl_lo_reg;
		sda_lo_next = sda_lo_reg;
		nak_next    = nak_reg;
		edone_next  = 1'b0;
		case (eng_reg)
			E_IDLE: begin
				if (go) begin
					eng_next  = (op == OP_START) ? E_START :
						(op == OP_STOP) ? E_STOP : E_BITS;
					esh_next  = wbyte;
					erd_next  = (op == OP_RD);
					eack_next = ack_send;
					ph_next   = 2'h0;
					bit_next  = 4'h0;
					div_next  = 8'h00;
				end
			end
			E_START: begin
				if (tick) begin
					ph_next = ph_reg + 2'h1;
					case (ph_reg)
						2'h0: sda_lo_next = 1'b0;
						2'h1: scl_lo_next = 1'b0;
						2'h2: sda_lo_next = 1'b1;
						default: begin
							scl_lo_next = 1'b1;
							eng_next    = E_IDLE;
							edone_next  = 1'b1;
						end
					endcase
				end
			end
			E_STOP: begin
				if (tick) begin
					ph_next = ph_reg + 2'h1;
					case (ph_reg)
						2'h0: sda_lo_next = 1'b1;
						2'h1: scl_lo_next = 1'b0;
						2'h2: sda_lo_next = 1'b0;
						default: begin
							eng_next   = E_IDLE;
							edone_next = 1'b1;
						end
					endcase
				end
			end
			E_BITS: begin
				if (tick) begin
					ph_next = ph_reg + 2'h1;
					case (ph_reg)
						2'h0: sda_lo_next = (bit_reg == `HTR_ACK_BIT) ?
							(erd_reg & eack_reg) : (~erd_reg & ~esh_reg[7]);
						2'h1: scl_lo_next = 1'b0;
						2'h2: begin
							if (bit_reg == `HTR_ACK_BIT) nak_next = sda_sync_reg[1];
							else esh_next = {esh_reg[6:0], sda_sync_reg[1]};
						end
						default: begin
							scl_lo_next = 1'b1;
							bit_next    = bit_reg + 4'h1;
							if (bit_reg == `HTR_ACK_BIT) begin
								eng_next   = E_IDLE;
								edone_next = 1'b1;
							end
						end
					endcase
				end
			end
			default: eng_next = E_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			eng_reg    <= E_IDLE;
			div_reg    <= 8'h00;
			ph_reg     <= 2'h0;
			bit_reg    <= 4'h0;
			esh_reg    <= 8'h00;
			erd_reg    <= 1'b0;
			eack_reg   <= 1'b0;
			scl_lo_reg <= 1'b0;
			sda_lo_reg <= 1'b0;
			nak_reg    <= 1'b0;
			edone_reg  <= 1'b0;
		end else begin
			eng_reg    <= eng_next;
			div_reg    <= div_next;
			ph_reg     <= ph_next;
			bit_reg    <= bit_next;
			esh_reg    <= esh_next;
			erd_reg    <= erd_next;
			eack_reg   <= eack_next;
			scl_lo_reg <= scl_lo_next;
			sda_lo_reg <= sda_lo_next;
			nak_reg    <= nak_next;
			edone_reg  <= edone_next;
		end
	end

	// ----------------------------------------
	// measurement sequencer
	// ----------------------------------------
	htr_hst_e    st_reg, st_next;
	logic [3:0]  idx_reg, idx_next;
	logic [1:0]  ir_reg, ir_next;
	logic [31:0] cnt_reg, cnt_next;
	logic        calok_reg, calok_next;
	logic        poll_reg, poll_next;
	logic        crcon_reg, crcon_next;
	logic [55:0] rbuf_reg, rbuf_next;
	logic        done_reg, done_next;
	logic        err_reg, err_next;
	logic [19:0] hum_reg, hum_next;
	logic [19:0] tmp_reg, tmp_next;
	logic [13:0] rh_reg, rh_next;
	logic [15:0] tc_reg, tc_next;
	logic [47:0] data48;
	logic        crc_ok;
	logic [33:0] rh_prod;
	logic [34:0] t_prod;
	logic        xfer;
	int unsigned lim;

	assign data48  = crcon_reg ? rbuf_reg[55:8] : rbuf_reg[47:0];
	assign crc_ok  = ~crcon_reg || (htr_crc8(rbuf_reg[55:8]) == rbuf_reg[7:0]);
	assign rh_prod = 34'(data48[39:20]) * `HTR_RH_SCALE;
	assign t_prod  = 35'(data48[19:0]) * `HTR_T_SCALE;
	assign xfer    = (st_reg == S_STAT) || (st_reg == S_INIT) || (st_reg == S_TRIG) ||
		(st_reg == S_READ);
	assign go      = xfer && (eng_reg == E_IDLE) && ~edone_reg;

	always_comb begin
		op       = OP_STOP;
		wbyte    = 8'h00;
		ack_send = 1'b0;
		if (idx_reg == 4'h0) begin
			op = OP_START;
		end else if (idx_reg == 4'h1) begin
			op    = OP_WR;
			wbyte = (st_reg == S_STAT || st_reg == S_READ) ? `HTR_RD_ADDR : `HTR_WR_ADDR;
		end else begin
			case (st_reg)
				S_STAT: if (idx_reg == `HTR_HDR) op = OP_RD;
				S_INIT: begin
					if (idx_reg < `HTR_HDR + `HTR_WR_LEN) begin
						op    = OP_WR;
						wbyte = (idx_reg != `HTR_HDR) ? `HTR_INIT_VAL :
							(ir_reg == 2'h0) ? `HTR_INIT_R0 :
							(ir_reg == 2'h1) ? `HTR_INIT_R1 : `HTR_INIT_R2;
					end
				end
				S_TRIG: begin
					if (idx_reg < `HTR_HDR + `HTR_WR_LEN) begin
						op    = OP_WR;
						wbyte = (idx_reg == `HTR_HDR) ? `HTR_CMD_TRIG :
							(idx_reg == `HTR_HDR + 4'h1) ? `HTR_TRIG_P0 : `HTR_TRIG_P1;
					end
				end
				S_READ: begin
					if (idx_reg < `HTR_HDR + `HTR_NDATA ||
						(idx_reg == `HTR_HDR + `HTR_NDATA && crcon_reg)) begin
						op       = OP_RD;
						ack_send = (idx_reg < `HTR_HDR + `HTR_NDATA - 4'h1) ||
							(idx_reg == `HTR_HDR + `HTR_NDATA - 4'h1 && crcon_reg);
					end
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		st_next    = st_reg;
		idx_next   = idx_reg;
		ir_next    = ir_reg;
		cnt_next   = cnt_reg + 32'h1;
		calok_next = calok_reg;
		poll_next  = poll_reg;
		crcon_next = crcon_reg;
		rbuf_next  = rbuf_reg;
		done_next  = 1'b0;
		err_next   = 1'b0;
		hum_next   = hum_reg;
		tmp_next   = tmp_reg;
		rh_next    = rh_reg;
		tc_next    = tc_reg;
		case (st_reg)
			S_PWR:   lim = PWR_CYC;
			S_GAP:   lim = GAP_CYC;
			S_CONV:  lim = CONV_CYC;
			default: lim = POLL_CYC;
		endcase
		case (st_reg)
			S_PWR: if (cnt_reg == lim - 1) st_next = S_IDLE;
			S_IDLE: begin
				if (meas_req) begin
					crcon_next = crc_en;
					poll_next  = 1'b0;
					idx_next   = 4'h0;
					cnt_next   = 32'h0;
					st_next    = calok_reg ? S_GAP : S_STAT;
				end
			end
			S_GAP, S_CONV, S_POLLW: begin
				if (cnt_reg == lim - 1) begin
					idx_next = 4'h0;
					st_next  = (st_reg == S_GAP) ? S_TRIG : S_STAT;
					if (st_reg == S_CONV) poll_next = 1'b1;
				end
			end
			default: begin
				if (edone_reg) begin
					idx_next = idx_reg + 4'h1;
					cnt_next = 32'h0;
					if (op == OP_RD) rbuf_next = {rbuf_reg[47:0], esh_reg};
					if (op == OP_WR && nak_reg) idx_next = `HTR_HDR + `HTR_NDATA + 4'h1;
					if (op == OP_STOP) begin
						idx_next = 4'h0;
						case (st_reg)
							S_STAT: begin
								if (poll_reg) begin
									st_next = rbuf_reg[`HTR_BUSY_BIT] ? S_POLLW : S_READ;
								end else if ((rbuf_reg[7:0] & `HTR_CAL_MASK) != `HTR_CAL_MASK) begin
									st_next = S_INIT;
									ir_next = 2'h0;
								end else begin
									calok_next = 1'b1;
									st_next    = S_GAP;
								end
							end
							S_INIT: begin
								ir_next = ir_reg + 2'h1;
								if (ir_reg == `HTR_LAST_REG) begin
									calok_next = 1'b1;
									st_next    = S_GAP;
								end
							end
							S_TRIG: st_next = S_CONV;
							default: begin
								if (!crc_ok) begin
									err_next = 1'b1;
									st_next  = S_GAP;
								end else begin
									hum_next  = data48[39:20];
									tmp_next  = data48[19:0];
									rh_next   = rh_prod[33:20];
									tc_next   = 16'(t_prod[34:20]) - `HTR_T_OFS;
									done_next = 1'b1;
									st_next   = S_IDLE;
								end
							end
						endcase
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg    <= S_PWR;
			idx_reg   <= 4'h0;
			ir_reg    <= 2'h0;
			cnt_reg   <= 32'h0;
			calok_reg <= 1'b0;
			poll_reg  <= 1'b0;
			crcon_reg <= 1'b0;
			rbuf_reg  <= 56'h0;
			done_reg  <= 1'b0;
			err_reg   <= 1'b0;
			hum_reg   <= 20'h0;
			tmp_reg   <= 20'h0;
			rh_reg    <= 14'h0;
			tc_reg    <= 16'h0;
		end else begin
			st_reg    <= st_next;
			idx_reg   <= idx_next;
			ir_reg    <= ir_next;
			cnt_reg   <= cnt_next;
			calok_reg <= calok_next;
			poll_reg  <= poll_next;
			crcon_reg <= crcon_next;
			rbuf_reg  <= rbuf_next;
			done_reg  <= done_next;
			err_reg   <= err_next;
			hum_reg   <= hum_next;
			tmp_reg   <= tmp_next;
			rh_reg    <= rh_next;
			tc_reg    <= tc_next;
		end
	end

	assign bus.h_scl_o      = 1'b0;
	assign bus.h_scl_oe_n   = ~scl_lo_reg;
	assign bus.h_sda_o      = 1'b0;
	assign bus.h_sda_oe_n   = ~sda_lo_reg;
	assign busy             = (st_reg != S_IDLE);
	assign done             = done_reg;
	assign crc_err          = err_reg;
	assign humidity_raw_value = hum_reg;
	assign temp_raw_value   = tmp_reg;
	assign rh_centi         = rh_reg;
	assign temp_centi       = $signed(tc_reg);
endmodule : htr_host

// file: htr_link_chk.sv
// Purpose: wire checks of the two-wire link
// Assumes: 100 cycles per quarter bit
// Notes:   watches interface signals only
`timescale 1ns/1ps
module htr_link_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic h_scl_o,
	input wire logic h_scl_oe_n,
	input wire logic h_sda_o,
	input wire logic h_sda_oe_n,
	input wire logic d_sda_o,
	input wire logic d_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	logic [9:0] lo_cnt_reg;
	logic [9:0] lo_cnt_next;
	always_comb lo_cnt_next = scl ? 10'h0 : lo_cnt_reg + {9'h0, ~&lo_cnt_reg};
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) lo_cnt_reg <= 10'h0;
		else lo_cnt_reg <= lo_cnt_next;
	end
	// ----------------
	// assertions
	// ----------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	drive_low_a: assert property (!h_scl_o && !h_sda_o && !d_sda_o)
		else $error("pin driven high");
	dev_edge_a: assert property ($changed(d_sda_oe_n) |-> !scl && lo_cnt_reg < 10'h010)
		else $error("sensor data moved outside low phase");
	both_low_a: assert property (!d_sda_oe_n && !h_sda_oe_n |-> !scl)
		else $error("both ends pull data with clock high");
	scl_low_a: assert property ($fell(h_scl_oe_n) |=> !scl [*8])
		else $error("clock low phase too short");
	scl_high_a: assert property ($rose(scl) |=> scl [*8])
		else $error("clock high phase too short");
	start_clk_a: assert property ($fell(sda) && scl |-> ##[1:150] !scl)
		else $error("no clock after start");
	low_bound_a: assert property (!scl |-> lo_cnt_reg < 10'h258)
		else $error("clock held low too long");
	stop_idle_a: assert property ($rose(h_sda_oe_n) && scl |=> scl [*8])
		else $error("clock moved right after stop");
endmodule : htr_link_chk

// file: tb_top.sv
// Purpose: both ends joined, results and wire checked
// Assumes: shortened counts
// Notes:   cal_in held low, so the first cycle runs the init writes
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0, rst_n = 1'b0, meas_req = 1'b0, crc_en = 1'b0;
	logic [19:0] hum = 20'h0, tmp = 20'h0, h_out, t_out;
	logic busy, done, crc_err, meas_busy, pscl = 1'b1, psda = 1'b1, cal = 1'b0;
	logic [13:0] rh_centi;
	logic signed [15:0] temp_centi;
	logic [7:0] sh;
	logic [7:0] q[$];
	int error_cnt = 0, check_count = 0, nb = 0;
	int n_err = 0, n_init = 0, n_trig = 0, n_busy = 0, n_stat = 0;
	int cyc = 0, t_trig = 0, t_first = 0;
	always #12.5 sys_clk = ~sys_clk;
	htr_if link ();
	htr_host #(.PWR_CYC(2000), .GAP_CYC(500), .CONV_CYC(3000), .POLL_CYC(500)) htr_host_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .bus(link), .meas_req(meas_req), .crc_en(crc_en),
		.busy(busy), .done(done), .crc_err(crc_err), .humidity_raw_value(h_out),
		.temp_raw_value(t_out), .rh_centi(rh_centi), .temp_centi(temp_centi));
	htr_sensor #(.MEAS_CYC(8000)) htr_sensor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.bus(link), .humidity_raw_value(hum), .temp_raw_value(tmp), .cal_in(cal),
		.meas_busy(meas_busy));
	htr_link_chk htr_link_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n), .h_scl_o(link.h_scl_o),
		.h_scl_oe_n(link.h_scl_oe_n), .h_sda_o(link.h_sda_o), .h_sda_oe_n(link.h_sda_oe_n),
		.d_sda_o(link.d_sda_o), .d_sda_oe_n(link.d_sda_oe_n), .scl(link.scl), .sda(link.sda));
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	task automatic wait_for(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 150000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk(s, v);
	endtask : wait_for
	// ----------------
	// wire monitor
	// ----------------
	task automatic frame_end();
		logic [7:0] c;
		c = 8'hff;
		chk(q[0] | 8'h01, 8'h71);
		if (q.size() == 2 && n_trig == 0) n_stat++;
		if (q.size() == 2 && q[1][7]) n_busy++;
		if (q.size() > 3 && q[1] == 8'hac) begin
			n_trig++;
			t_trig = cyc;
		end
		if (q[0] == 8'h71 && q.size() > 1)
			chk(q[1] & 8'h18, (n_init == 3) ? 8'h18 : 8'h00);
		if (q.size() > 3 && q[1] == 8'hac) chk({q[2], q[3]}, 16'h3300);
		if (q[0] == 8'h70 && q[1] inside {8'h1b, 8'h1c, 8'h1e}) n_init++;
		if (q.size() < 7) return;
		chk({q[1][7], q[2], q[3], q[4], q[5], q[6]}, {1'b0, hum, tmp});
		chk(q.size(), crc_en ? 8 : 7);
		for (int i = 1; i < 7; i++)
			for (int k = 7; k >= 0; k--)
				c = (c[7] ^ q[i][k]) ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
		if (q.size() == 8) chk(q[7], c);
	endtask : frame_end
	always @(posedge sys_clk) begin
		pscl <= link.scl;
		psda <= link.sda;
		if (crc_err === 1'b1) n_err++;
		if (rst_n) cyc++;
		if (!rst_n) q.delete();
		else if (link.scl && pscl && psda && !link.sda) begin
			nb = 0;
			q.delete();
			if (t_first == 0) t_first = cyc;
			if (t_trig != 0) chk(cyc - t_trig >= 3000, 1'b1);
			t_trig = 0;
		end else if (link.scl && pscl && !psda && link.sda && q.size() > 0) frame_end();
		else if (link.scl && !pscl && nb == 8) begin
			nb = 0;
			if (q[0] == 8'h70 || q.size() == 1) chk(link.sda, 1'b0);
		end else if (link.scl && !pscl) begin
			sh = {sh[6:0], link.sda};
			nb++;
			if (nb == 8) q.push_back(sh);
		end
	end
	// ----------------
	// tests
	// ----------------
	initial begin
		void'($urandom(43));
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			wait_for(busy, 1'b0);
			@(posedge sys_clk);
			hum <= 20'($urandom());
			tmp <= 20'($urandom());
			crc_en <= (m == 0);
			meas_req <= 1'b1;
			wait_for(busy, 1'b1);
			@(posedge sys_clk);
			meas_req <= 1'b0;
			wait_for(done, 1'b1);
			chk({h_out, t_out}, {hum, tmp});
			chk(rh_centi, 14'((longint'(hum) * 10000) >> 20));
			chk({temp_centi}, {16'(((longint'(tmp) * 20000) >> 20) - 5000)});
			chk(meas_busy, 1'b0);
			$display("test %0d finished", m);
		end
		chk(n_err, 48'h0);
		chk(n_init, 48'h3);
		chk(n_trig, 48'h2);
		chk(n_stat, 48'h1);
		chk(n_busy > 0, 1'b1);
		chk(t_first >= 2000, 1'b1);
		tally_and_finish();
	end
	initial begin
		repeat (240000) @(posedge sys_clk);
		error_cnt++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule : tb_top
